// [hw/rspctl_pkg.sv]
package rspctl_pkg;

    // ----------------------------------------------------------------
    // register map, byte addresses (printed offsets not all multiples of 4)
    // ----------------------------------------------------------------
    localparam logic [3:0] MOD_CTRL_INDEX = 4'h9;
    localparam logic [3:0] CAL_CTRL_INDEX = 4'hA;
    localparam logic [11:0] MOD_CTRL_ADDR = {6'h00, MOD_CTRL_INDEX, 2'h0};
    localparam logic [11:0] CAL_CTRL_ADDR = {6'h00, CAL_CTRL_INDEX, 2'h0};

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int DEMOD_EN_BIT = 7;
    localparam int MOD_EN_BIT = 6;
    localparam int PHASE_MSB = 5;
    localparam int PHASE_LSB = 2;
    localparam int MOD_FIXED_ONE_BIT = 1;
    localparam int CLK_SRC_BIT = 0;
    localparam int CAL_EN_BIT = 7;
    localparam int FREQ_BIT = 2;
    localparam int REF_INT_BIT = 1;
    localparam int CAL_FIXED_ONE_BIT = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] MOD_CTRL_RESET = 8'h02;
    localparam logic [7:0] CAL_CTRL_RESET = 8'h03;

    // phase step count in units of 11.25 degrees
    localparam logic [4:0] PHASE_STEPS_PER_CODE_32K = 5'h01;
    localparam logic [4:0] PHASE_STEPS_PER_CODE_64K = 5'h02;

endpackage

// [hw/rspctl_regs.sv]
`timescale 1ns/1ps

// Behaviour
// - demodulator enable bit 7 turns channel-1 demodulation on; off by default
// - modulator enable bit 6 turns channel-1 modulation on; off by default
// - at 32 kHz phase is code times 11.25 degrees, default 0
// - at 64 kHz top phase bit ignored, steps of 22.5 degrees
// - clock source bit 0: 0 internal clock, 1 external clock
// - internal clock frequency bit: 0 gives 32 kHz (default), 1 gives 64 kHz
// - calibration bit 7 runs offset calibration while 1; default 0
// - reference bit 1: 0 external, 1 internal supply midpoint (default)
module rspctl_regs
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // respiration and calibration controls
    output logic demodulator_enable,
    output logic modulator_enable,
    output logic [4:0] demodulation_phase_steps,
    output logic breathing_clock_source,
    output logic breathing_clock_frequency,
    output logic offset_calibration_enable,
    output logic leg_drive_reference_internal
);
    import rspctl_pkg::*;

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [7:0] mod_ctrl_r;
    logic [7:0] cal_ctrl_r;
    logic access_w;
    logic hit_mod;
    logic hit_cal;
    logic [4:0] phase_steps_nxt;
    logic fast_internal_w;

    assign access_w = psel && !penable;
    assign hit_mod = (paddr == MOD_CTRL_ADDR);
    assign hit_cal = (paddr == CAL_CTRL_ADDR);

    // writes take effect in the access cycle; only byte lane 0 carries data
    // reserved bits are stored as written; keeping them right is software's duty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_ctrl_r <= MOD_CTRL_RESET;
            cal_ctrl_r <= CAL_CTRL_RESET;
        end else if (psel && penable && pready && pwrite && pstrb[0]) begin
            if (hit_mod) begin
                mod_ctrl_r <= pwdata[7:0];
            end
            if (hit_cal) begin
                cal_ctrl_r <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // apb answer: no wait state, registered read data and error
    // ----------------------------------------------------------------
    // pready goes high on the cycle after setup, so every transfer is two cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access_w;
            pslverr <= access_w && !(hit_mod || hit_cal);
            if (access_w && !pwrite && hit_mod) begin
                prdata <= {24'h00_0000, mod_ctrl_r};
            end else if (access_w && !pwrite && hit_cal) begin
                prdata <= {24'h00_0000, cal_ctrl_r};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // decoded controls
    // ----------------------------------------------------------------
    // fast internal clock taken from the stored bits, not the registered output,
    // so the phase steps move in the same cycle as every other control
    assign fast_internal_w = cal_ctrl_r[FREQ_BIT] && !mod_ctrl_r[CLK_SRC_BIT];

    // phase in 11.25 degree steps; 64 kHz drops the top code bit and doubles the step
    always_comb begin
        if (fast_internal_w) begin
            phase_steps_nxt = {1'b0, mod_ctrl_r[PHASE_MSB-1:PHASE_LSB], 1'b0};
        end else begin
            phase_steps_nxt = {1'b0, mod_ctrl_r[PHASE_MSB:PHASE_LSB]};
        end
    end

    // outputs registered so they come straight from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            demodulator_enable <= 1'b0;
            modulator_enable <= 1'b0;
            demodulation_phase_steps <= 5'h00;
            breathing_clock_source <= 1'b0;
            offset_calibration_enable <= 1'b0;
            leg_drive_reference_internal <= 1'b1;
        end else begin
            demodulator_enable <= mod_ctrl_r[DEMOD_EN_BIT];
            modulator_enable <= mod_ctrl_r[MOD_EN_BIT];
            demodulation_phase_steps <= phase_steps_nxt;
            breathing_clock_source <= mod_ctrl_r[CLK_SRC_BIT];
            offset_calibration_enable <= cal_ctrl_r[CAL_EN_BIT];
            leg_drive_reference_internal <= cal_ctrl_r[REF_INT_BIT];
        end
    end

    // frequency select is direct from the register, no extra delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            breathing_clock_frequency <= 1'b0;
        end else begin
            breathing_clock_frequency <= cal_ctrl_r[FREQ_BIT];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_demod_follows: assert property (@(posedge pclk) disable iff (!presetn)
        demodulator_enable == $past(mod_ctrl_r[DEMOD_EN_BIT]))
        else $error("demodulator enable does not follow register");
    chk_mod_follows: assert property (@(posedge pclk) disable iff (!presetn)
        modulator_enable == $past(mod_ctrl_r[MOD_EN_BIT]))
        else $error("modulator enable does not follow register");
    chk_phase_32k: assert property (@(posedge pclk) disable iff (!presetn)
        !cal_ctrl_r[FREQ_BIT] && mod_ctrl_r[PHASE_MSB:PHASE_LSB] == 4'hF
        |=> demodulation_phase_steps == 5'h0F)
        else $error("32 kHz phase code not mapped one step per code");
    chk_phase_64k: assert property (@(posedge pclk) disable iff (!presetn)
        demodulation_phase_steps[0] == 1'b1 |-> !breathing_clock_frequency
            || $past(mod_ctrl_r[CLK_SRC_BIT]))
        else $error("64 kHz phase not in even steps");
    chk_src_follows: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(mod_ctrl_r[CLK_SRC_BIT]) |=> breathing_clock_source)
        else $error("clock source not following register");
    chk_freq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(cal_ctrl_r[FREQ_BIT]) |=> breathing_clock_frequency == $past(cal_ctrl_r[FREQ_BIT]))
        else $error("frequency select not following register");
    chk_cal_follows: assert property (@(posedge pclk) disable iff (!presetn)
        offset_calibration_enable == $past(cal_ctrl_r[CAL_EN_BIT]))
        else $error("calibration enable does not follow register");
    chk_ref_follows: assert property (@(posedge pclk) disable iff (!presetn)
        leg_drive_reference_internal == $past(cal_ctrl_r[REF_INT_BIT]))
        else $error("reference select does not follow register");
    chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

    // ----------------------------------------------------------------
    // apb transfer checks
    // ----------------------------------------------------------------
    // a full-lane write to the modulation word lands at the access edge
    chk_write_mod: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && pstrb[0] && hit_mod
        |=> mod_ctrl_r == $past(pwdata[7:0]))
        else $error("modulation register write did not land");
    // a full-lane write to the calibration word lands at the access edge
    chk_write_cal: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && pstrb[0] && hit_cal
        |=> cal_ctrl_r == $past(pwdata[7:0]))
        else $error("calibration register write did not land");
    // lane 0 masked: neither register may move
    chk_strobe_refused: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && !pstrb[0]
        |=> $stable(mod_ctrl_r) && $stable(cal_ctrl_r))
        else $error("masked write changed a register");
    // unmapped write must not reach either register
    chk_unmapped_write: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !(hit_mod || hit_cal)
        |=> $stable(mod_ctrl_r) && $stable(cal_ctrl_r))
        else $error("unmapped write changed a register");
    // unmapped setup answers with an error and zero data
    chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !(hit_mod || hit_cal)
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    // read of the modulation word returns the stored byte in lane 0
    chk_read_mod: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit_mod
        |=> prdata == {24'h00_0000, $past(mod_ctrl_r)})
        else $error("modulation register read data wrong");
    // read of the calibration word returns the stored byte in lane 0
    chk_read_cal: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit_cal
        |=> prdata == {24'h00_0000, $past(cal_ctrl_r)})
        else $error("calibration register read data wrong");
    // outside the answer cycle the bus outputs rest at zero
    chk_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> !pslverr && prdata == 32'h0000_0000)
        else $error("bus outputs not quiet outside answer");

    // ----------------------------------------------------------------
    // decoded control checks
    // ----------------------------------------------------------------
    // slow or external clock: one 11.25 degree step per code
    chk_phase_32k_map: assert property (@(posedge pclk) disable iff (!presetn)
        !cal_ctrl_r[FREQ_BIT] || mod_ctrl_r[CLK_SRC_BIT] |=>
        demodulation_phase_steps == {1'b0, $past(mod_ctrl_r[PHASE_MSB:PHASE_LSB])})
        else $error("32 kHz phase steps wrong");
    // fast internal clock: top code bit ignored, two steps per code
    chk_phase_64k_map: assert property (@(posedge pclk) disable iff (!presetn)
        cal_ctrl_r[FREQ_BIT] && !mod_ctrl_r[CLK_SRC_BIT] |=>
        demodulation_phase_steps == {1'b0, $past(mod_ctrl_r[PHASE_MSB-1:PHASE_LSB]), 1'b0})
        else $error("64 kHz phase steps wrong");
    // no phase code reaches 180 degrees
    chk_phase_range: assert property (@(posedge pclk) disable iff (!presetn)
        demodulation_phase_steps[4] == 1'b0)
        else $error("phase steps out of range");
    // going back to the internal clock reaches the output a cycle later
    chk_src_falls: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(mod_ctrl_r[CLK_SRC_BIT]) |=> !breathing_clock_source)
        else $error("clock source not returning to internal");

endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import rspctl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic dem, modu, src, frq, cal, lref;
    logic [4:0] steps;
    int errors = 0;
    int checked = 0;
    rspctl_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .demodulator_enable(dem), .modulator_enable(modu),
        .demodulation_phase_steps(steps), .breathing_clock_source(src),
        .breathing_clock_frequency(frq), .offset_calibration_enable(cal),
        .leg_drive_reference_internal(lref));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic stop_test();
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer; read data judged only on reads
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
        input logic [3:0] s, input logic [7:0] er, input logic ee);
        bit done;
        done = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h000000, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 20 && !done; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                done = 1;
                if (!w) chk("prdata", {24'h000000, er}, prdata);
                chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!done) begin
            errors++;
            stop_test();
        end
    endtask
    // controls settle after the write edge; two edges leave margin
    task automatic outs(input logic [10:0] e);
        repeat (2) @(posedge pclk);
        #1;
        chk("controls", {21'h0, e}, {21'h0, dem, modu, steps, src, frq, cal, lref});
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        outs(11'b0_0_00000_0_0_0_1);
        apb(1'b0, MOD_CTRL_ADDR, 8'h00, 4'hF, 8'h02, 1'b0);
        apb(1'b0, CAL_CTRL_ADDR, 8'h00, 4'hF, 8'h03, 1'b0);
    endtask
    task automatic t_enables();
        apb(1'b1, MOD_CTRL_ADDR, 8'hC2, 4'hF, 8'h00, 1'b0);
        outs(11'b1_1_00000_0_0_0_1);
        apb(1'b1, MOD_CTRL_ADDR, 8'h42, 4'hF, 8'h00, 1'b0);
        outs(11'b0_1_00000_0_0_0_1);
        apb(1'b0, MOD_CTRL_ADDR, 8'h00, 4'hF, 8'h42, 1'b0);
    endtask
    // every phase code under each clock choice
    task automatic t_phase(input logic [7:0] calv, input logic ext);
        apb(1'b1, CAL_CTRL_ADDR, calv, 4'hF, 8'h00, 1'b0);
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, MOD_CTRL_ADDR, {2'b00, 4'(c), 1'b1, ext}, 4'hF, 8'h00, 1'b0);
            if (calv[2] && !ext) begin
                outs({2'b00, 1'b0, 3'(c), 1'b0, 1'b0, 1'b1, 1'b0, 1'b1});
            end else begin
                outs({2'b00, 1'b0, 4'(c), ext, calv[2], 1'b0, 1'b1});
            end
        end
    endtask
    task automatic t_calib();
        apb(1'b1, MOD_CTRL_ADDR, 8'h02, 4'hF, 8'h00, 1'b0);
        apb(1'b1, CAL_CTRL_ADDR, 8'h85, 4'hF, 8'h00, 1'b0);
        outs(11'b0_0_00000_0_1_1_0);
        apb(1'b0, CAL_CTRL_ADDR, 8'h00, 4'hF, 8'h85, 1'b0);
    endtask
    // masked lane and unmapped places leave registers alone
    task automatic t_refused();
        apb(1'b1, MOD_CTRL_ADDR, 8'hFF, 4'hE, 8'h00, 1'b0);
        apb(1'b0, MOD_CTRL_ADDR, 8'h00, 4'hF, 8'h02, 1'b0);
        apb(1'b1, 12'h02C, 8'hFF, 4'hF, 8'h00, 1'b1);
        apb(1'b0, 12'h02C, 8'h00, 4'hF, 8'h00, 1'b1);
        outs(11'b0_0_00000_0_1_1_0);
    endtask
    // reset in mid-run brings every default back
    task automatic t_midreset();
        apb(1'b1, MOD_CTRL_ADDR, 8'hC6, 4'hF, 8'h00, 1'b0);
        outs(11'b1_1_00010_0_1_1_0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        outs(11'b0_0_00000_0_0_0_1);
        apb(1'b0, MOD_CTRL_ADDR, 8'h00, 4'hF, 8'h02, 1'b0);
        apb(1'b0, CAL_CTRL_ADDR, 8'h00, 4'hF, 8'h03, 1'b0);
    endtask
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_enables();
        t_phase(8'h03, 1'b0);
        t_phase(8'h07, 1'b0);
        t_phase(8'h07, 1'b1);
        t_calib();
        t_refused();
        t_midreset();
        stop_test();
    end
endmodule
